// ==== fbp_pkg.sv ====
package fbp_pkg;

  // ****************************************************************
  // Widths and clock
  // ****************************************************************
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CLK_NS = 10;

  // ****************************************************************
  // Host requests
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_PROGRAM   = 3'h1,
    OP_ERASE     = 3'h2,
    OP_SEC_ENTER = 3'h3,
    OP_SEC_EXIT  = 3'h4,
    OP_SEC_LOCK  = 3'h5,
    OP_HW_RESET  = 3'h6
  } fbp_op_t;

  // ****************************************************************
  // Command cycles (word mode)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] UNLOCK_A1      = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2      = 21'h0002AA;
  localparam logic [DATA_W-1:0] UNLOCK_D1      = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_D2      = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM    = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SET  = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_ERASE_SECT = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_SEC_ENTER  = 16'h0088;
  localparam logic [DATA_W-1:0] CMD_SEC_EXIT   = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_EXIT_ZERO  = 16'h0000;
  localparam logic [DATA_W-1:0] CMD_PROT_SET   = 16'h0060;
  localparam logic [DATA_W-1:0] CMD_PROT_VFY   = 16'h0040;
  localparam logic [ADDR_W-1:0] PROT_ADDR_OFS  = 21'h000002;

  // ****************************************************************
  // Boot-end address map (top boot, word addresses)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] BOOT_AREA_BASE  = 21'h1F8000;
  localparam logic [ADDR_W-1:0] BOOT_OUTER_BASE = 21'h1FE000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int T_SETUP_NS  = 20;
  localparam int T_PULSE_NS  = 40;
  localparam int T_HOLD_NS   = 20;
  localparam int T_BUSY_NS   = 100;
  localparam int T_RESET_NS  = 500;
  localparam int T_HV_NS     = 4000;
  localparam int SYNC_CYC    = 3;
  localparam logic [7:0]  SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  PULSE_CYC = 8'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  HOLD_CYC  = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  RDX_CYC   = 8'(SYNC_CYC);
  localparam logic [15:0] BUSY_CYC  = 16'((T_BUSY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RESET_CYC = 16'((T_RESET_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] HV_CYC    = 16'((T_HV_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ==== fbp_bus_cycle.sv ====
`timescale 1ns/1ps
module fbp_bus_cycle
  import fbp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              start,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] fl_dq_in,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [DATA_W-1:0]      fl_dq_out,
  output logic                   fl_dq_oe_n,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n
);

  typedef enum logic [1:0] {
    CY_IDLE  = 2'b00,
    CY_SETUP = 2'b01,
    CY_PULSE = 2'b10,
    CY_HOLD  = 2'b11
  } fbp_cy_t;

  fbp_cy_t          state;
  logic [7:0]       cnt;
  logic             is_wr;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic [DATA_W-1:0] dq_s3;

  // ****************************************************************
  // Data bus synchroniser
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
    end else begin
      dq_s1 <= fl_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // ****************************************************************
  // One asynchronous bus cycle: setup, strobe, hold
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= CY_IDLE;
      cnt        <= '0;
      is_wr      <= 1'b0;
      done       <= 1'b0;
      rdata      <= '0;
      fl_addr    <= '0;
      fl_dq_out  <= '0;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
      fl_we_n    <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state)
        CY_IDLE: begin
          if (start) begin
            state      <= CY_SETUP;
            cnt        <= SETUP_CYC;
            is_wr      <= wr;
            fl_addr    <= addr;
            fl_dq_out  <= wdata;
            fl_dq_oe_n <= !wr;
            fl_ce_n    <= 1'b0;
          end
        end
        CY_SETUP: begin
          if (cnt <= 8'h01) begin
            state   <= CY_PULSE;
            cnt     <= is_wr ? PULSE_CYC : 8'(PULSE_CYC + RDX_CYC);  // Reads cover the synchroniser delay
            fl_we_n <= !is_wr;
            fl_oe_n <= is_wr;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        CY_PULSE: begin
          if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
          end else if (is_wr || dq_s2 == dq_s3) begin
            state   <= CY_HOLD;
            cnt     <= HOLD_CYC;
            rdata   <= dq_s3;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
          end
        end
        default: begin
          if (cnt <= 8'h01) begin
            state      <= CY_IDLE;
            done       <= 1'b1;
            fl_ce_n    <= 1'b1;
            fl_dq_oe_n <= 1'b1;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
      endcase
    end
  end

endmodule

// ==== fbp_host.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Host always drives the protect/accelerate pin to a defined level.
// - High voltage on reset pin is applied on request, but outer boot sectors stay refused while the pin is low.
// - After the entry sequence, boot-sector addresses reach the secured sector.
// - Lock: enter secured mode, then run protect algorithm, reset pin high or high voltage.
// - After locking, host issues the exit sequence before using the main array.
module fbp_host
  import fbp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              cmd_valid,
  input  wire fbp_op_t           cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic                   rsp_error,
  output logic [DATA_W-1:0]      rsp_rdata,
  input  wire logic              wp_level,
  input  wire logic              temp_unprotect,
  output logic                   secure_mode,
  output logic [ADDR_W-1:0]      fl_addr,
  output logic [DATA_W-1:0]      fl_dq_out,
  input  wire logic [DATA_W-1:0] fl_dq_in,
  output logic                   fl_dq_oe_n,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n,
  output logic                   fl_reset_n,
  output logic                   fl_hv_en,
  output logic                   protect_accel_pin,
  input  wire logic              fl_ready
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STEP = 3'b001,
    ST_WAIT = 3'b010,
    ST_GAP  = 3'b011,
    ST_POLL = 3'b100,
    ST_RST  = 3'b101,
    ST_HV   = 3'b110,
    ST_RESP = 3'b111
  } fbp_st_t;

  fbp_st_t           state;
  fbp_op_t           op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [2:0]        idx;
  logic [15:0]       cnt;
  logic              cyc_start;
  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic              err_q;
  logic              rdy_s1;
  logic              rdy_s2;
  logic              rdy_s3;
  logic              refuse;
  logic              is_write_op;
  logic [ADDR_W+DATA_W+1:0] step;

  // ****************************************************************
  // Command step table: {write, last, address, data}
  // ****************************************************************
  function automatic logic [ADDR_W+DATA_W+1:0] step_of(input fbp_op_t o, input logic [2:0] i,
                                                       input logic [ADDR_W-1:0] a,
                                                       input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] pa;
    pa = a | PROT_ADDR_OFS;
    if (o != OP_READ && o != OP_SEC_LOCK && i == 3'h0) begin
      step_of = {2'b10, UNLOCK_A1, UNLOCK_D1};
    end else if (o != OP_READ && o != OP_SEC_LOCK && i == 3'h1) begin
      step_of = {2'b10, UNLOCK_A2, UNLOCK_D2};
    end else begin
      case (o)
        OP_READ:      step_of = {2'b01, a, d};
        OP_PROGRAM:   step_of = (i == 3'h2) ? {2'b10, UNLOCK_A1, CMD_PROGRAM} : {2'b11, a, d};
        OP_ERASE: begin
          case (i)
            3'h2:    step_of = {2'b10, UNLOCK_A1, CMD_ERASE_SET};
            3'h3:    step_of = {2'b10, UNLOCK_A1, UNLOCK_D1};
            3'h4:    step_of = {2'b10, UNLOCK_A2, UNLOCK_D2};
            default: step_of = {2'b11, a, CMD_ERASE_SECT};
          endcase
        end
        OP_SEC_ENTER: step_of = {2'b11, UNLOCK_A1, CMD_SEC_ENTER};
        OP_SEC_EXIT:  step_of = (i == 3'h2) ? {2'b10, UNLOCK_A1, CMD_SEC_EXIT}
                                            : {2'b11, UNLOCK_A1, CMD_EXIT_ZERO};
        OP_SEC_LOCK: begin
          case (i)
            3'h0, 3'h1: step_of = {2'b10, pa, CMD_PROT_SET};
            3'h2:       step_of = {2'b10, pa, CMD_PROT_VFY};
            default:    step_of = {2'b01, pa, d};
          endcase
        end
        default:      step_of = {2'b01, a, d};
      endcase
    end
  endfunction

  assign step = step_of(op_q, idx, addr_q, wdata_q);

  // ****************************************************************
  // Request screening
  // ****************************************************************
  always_comb begin
    is_write_op = (cmd_op == OP_PROGRAM) || (cmd_op == OP_ERASE);
    refuse = 1'b0;
    if (secure_mode && (is_write_op || cmd_op == OP_READ) && cmd_addr < BOOT_AREA_BASE) begin
      refuse = 1'b1;
    end else if (secure_mode && cmd_op == OP_ERASE) begin
      refuse = 1'b1;
    end else if (!secure_mode && cmd_op == OP_SEC_LOCK) begin
      refuse = 1'b1;
    end else if (!secure_mode && !wp_level && is_write_op && cmd_addr >= BOOT_OUTER_BASE) begin
      refuse = 1'b1;
    end else if (fl_hv_en && cmd_op == OP_HW_RESET) begin
      refuse = 1'b1;
    end else if (cmd_op > OP_HW_RESET) begin
      refuse = 1'b1;
    end
  end

  // ****************************************************************
  // Ready pin synchroniser
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_s3 <= 1'b0;
    end else begin
      rdy_s1 <= fl_ready;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      op_q       <= OP_READ;
      addr_q     <= '0;
      wdata_q    <= '0;
      idx        <= '0;
      cnt        <= '0;
      cyc_start  <= 1'b0;
      err_q      <= 1'b0;
      fl_reset_n <= 1'b1;
      fl_hv_en   <= 1'b0;
      cmd_ready  <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      cmd_ready <= 1'b0;
      case (state)
        ST_IDLE: begin
          // An advertised ready is always honoured; a voltage change waits until the taken request is answered
          if (cmd_valid && cmd_ready) begin
            op_q    <= cmd_op;
            addr_q  <= cmd_addr;
            wdata_q <= cmd_wdata;
            idx     <= '0;
            err_q   <= refuse;
            if (refuse) begin
              state <= ST_RESP;
            end else if (cmd_op == OP_HW_RESET) begin
              state      <= ST_RST;
              cnt        <= RESET_CYC;
              fl_reset_n <= 1'b0;
            end else begin
              state <= ST_STEP;
            end
          end else if (temp_unprotect != fl_hv_en) begin
            state    <= ST_HV;
            fl_hv_en <= temp_unprotect;
            cnt      <= HV_CYC;
          end else begin
            cmd_ready <= 1'b1;
          end
        end
        ST_STEP: begin
          cyc_start <= 1'b1;
          state     <= ST_WAIT;
        end
        ST_WAIT: begin
          if (cyc_done && !step[ADDR_W+DATA_W]) begin
            idx   <= idx + 3'h1;
            state <= ST_STEP;
          end else if (cyc_done) begin
            if (op_q == OP_PROGRAM || op_q == OP_ERASE) begin
              state <= ST_GAP;
              cnt   <= BUSY_CYC;
            end else begin
              state <= ST_RESP;
            end
          end
        end
        ST_GAP: begin
          if (cnt <= 16'h0001) begin
            state <= ST_POLL;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_POLL: begin
          if (rdy_s2 && rdy_s3) begin
            state <= ST_RESP;
          end
        end
        ST_RST: begin
          if (cnt <= 16'h0001) begin
            if (!fl_reset_n) begin
              fl_reset_n <= 1'b1;
              cnt        <= RESET_CYC;
            end else begin
              state <= ST_RESP;
            end
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        ST_HV: begin
          if (cnt <= 16'h0001) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Answer to the requester
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state == ST_RESP);
      if (state == ST_RESP) begin
        rsp_error <= err_q;
        rsp_rdata <= err_q ? '0 : cyc_rdata;
      end
    end
  end

  // ****************************************************************
  // Secured-sector mode tracking
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      secure_mode <= 1'b0;
    end else if (state == ST_RESP && !err_q) begin
      if (op_q == OP_SEC_ENTER) begin
        secure_mode <= 1'b1;
      end else if (op_q == OP_SEC_EXIT || op_q == OP_HW_RESET) begin
        secure_mode <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Protect pin, never left undriven and never raised for speedup
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      protect_accel_pin <= 1'b0;
    end else begin
      protect_accel_pin <= wp_level;
    end
  end

  fbp_bus_cycle u_cycle (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .start      (cyc_start),
    .wr         (step[ADDR_W+DATA_W+1]),
    .addr       (step[ADDR_W+DATA_W-1:DATA_W]),
    .wdata      (step[DATA_W-1:0]),
    .fl_dq_in   (fl_dq_in),
    .done       (cyc_done),
    .rdata      (cyc_rdata),
    .fl_addr    (fl_addr),
    .fl_dq_out  (fl_dq_out),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_ce_n    (fl_ce_n),
    .fl_oe_n    (fl_oe_n),
    .fl_we_n    (fl_we_n)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  pin_follow_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $changed(wp_level) |=> protect_accel_pin == $past(wp_level)) else $error("protect pin lags");
  hv_reset_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    fl_hv_en |-> fl_reset_n) else $error("reset pulsed under high voltage");
  hv_settle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(fl_hv_en) |-> !cmd_ready [*8]) else $error("request taken before high voltage settled");
  sec_enter_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(secure_mode) |-> $past(op_q) == OP_SEC_ENTER && rsp_valid)
    else $error("secured mode without entry");
  lock_mode_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == ST_STEP && op_q == OP_SEC_LOCK) |-> secure_mode) else $error("lock outside secured mode");
  exit_first_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == ST_STEP && secure_mode && op_q inside {OP_READ, OP_PROGRAM}) |-> addr_q >= BOOT_AREA_BASE)
    else $error("main array used in secured mode");
  reset_leave_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == ST_RESP && op_q == OP_HW_RESET && !err_q) |=> !secure_mode) else $error("mode kept over reset");
  outer_guard_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == ST_STEP && op_q inside {OP_PROGRAM, OP_ERASE} && !secure_mode && addr_q >= BOOT_OUTER_BASE)
    |-> protect_accel_pin) else $error("outer boot write with pin low");
  cv_enter_c: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(secure_mode));
  cv_lock_c: cover property (@(posedge sys_clk) disable iff (!arst_n) rsp_valid && op_q == OP_SEC_LOCK);
  cv_hv_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    fl_hv_en && rsp_valid && op_q == OP_PROGRAM && !rsp_error);

endmodule

// ==== fbp_flash_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Flash device seen from the host pins
// ****************************************************************
module fbp_flash_model
  import fbp_pkg::*;
#(
  parameter logic FACTORY = 1'b0
)(
  input  wire logic [ADDR_W-1:0] fl_addr,
  input  wire logic [DATA_W-1:0] fl_dq_out,
  output logic      [DATA_W-1:0] fl_dq_in,
  input  wire logic              fl_ce_n,
  input  wire logic              fl_dq_oe_n,
  input  wire logic              fl_oe_n,
  input  wire logic              fl_we_n,
  input  wire logic              fl_reset_n,
  input  wire logic              protect_accel_pin,
  input  wire logic              slow,
  output logic                   fl_ready
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] prev;
  logic [DATA_W-1:0] hold;
  logic [DATA_W-1:0] rd;
  logic              sec;
  logic              locked;

  initial begin
    sec = 1'b0;
    locked = FACTORY;
    hold = 16'h0000;
    prev = 16'h0000;
    fl_ready = 1'b1;
  end

  // Read value: serial number for boot-area addresses in secured mode, else stored word or address pattern
  always @(fl_addr or sec or fl_oe_n) begin
    if (sec && fl_addr >= BOOT_AREA_BASE)
      rd = 16'hE500 ^ 16'(fl_addr[7:0]);
    else if (mem.exists(fl_addr))
      rd = mem[fl_addr];
    else
      rd = fl_addr[15:0] ^ 16'h3C3C;
  end

  // Released bus shows the inverse of the last word, not a stale copy
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~hold;
  always @(posedge fl_oe_n) hold = rd;

  // Write cycles are latched on the rising write strobe
  always @(posedge fl_we_n or negedge fl_reset_n) begin
    if (!fl_reset_n) begin
      sec = 1'b0;
      prev = 16'h0000;
    end else if (!fl_ce_n && !fl_dq_oe_n) begin // Host must be driving the data bus
      if (prev == CMD_PROGRAM) begin
        if (!sec && !(fl_addr >= BOOT_OUTER_BASE && !protect_accel_pin))
          mem[fl_addr] = fl_dq_out;
        else if (sec && !locked)
          mem[fl_addr] = mem[fl_addr]; // Serial words stay fixed in this model
        if (slow) begin
          fl_ready = 1'b0;
          fl_ready <= #300 1'b1;
        end
      end else begin
        if (fl_dq_out == CMD_SEC_ENTER) sec = 1'b1;
        if (fl_dq_out == CMD_SEC_EXIT) sec = 1'b0;
        if (fl_dq_out == CMD_PROT_VFY && sec) locked = 1'b1;
      end
      prev = fl_dq_out;
    end
  end
endmodule

// ==== flash_boot_sector_protection_bench.sv ====
`timescale 1ns/1ps
module flash_boot_sector_protection_bench;
  import fbp_pkg::*;
  logic sys_clk, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_error, wp_level, temp_unprotect, secure_mode;
  logic fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_hv_en, protect_accel_pin, fl_ready, slow, err;
  fbp_op_t           cmd_op;
  logic [ADDR_W-1:0] cmd_addr, fl_addr, a;
  logic [DATA_W-1:0] cmd_wdata, rsp_rdata, fl_dq_out, fl_dq_in, rd, d;
  logic [31:0]       rng;
  int                n_fail, n_compared, cyc, k;

  fbp_host u_dut (.sys_clk, .arst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid,
    .rsp_error, .rsp_rdata, .wp_level, .temp_unprotect, .secure_mode, .fl_addr, .fl_dq_out, .fl_dq_in,
    .fl_dq_oe_n, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_reset_n, .fl_hv_en, .protect_accel_pin, .fl_ready);
  fbp_flash_model u_flash (.fl_addr, .fl_dq_out, .fl_dq_in, .fl_ce_n, .fl_dq_oe_n, .fl_oe_n, .fl_we_n, .fl_reset_n,
    .protect_accel_pin, .slow, .fl_ready);

  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #(CLK_NS / 2) sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [15:0] serial(input logic [20:0] x);
    return 16'hE500 ^ {8'h00, x[7:0]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One request: hold until taken, then wait for its answer
  task automatic op(input fbp_op_t o, input logic [20:0] x, input logic [15:0] y);
    k = 0;
    cmd_op <= o;
    cmd_addr <= x;
    cmd_wdata <= y;
    cmd_valid <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 3000);
    cmd_valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 3000);
    if (k >= 3000) n_fail++;
    err = rsp_error;
    rd = rsp_rdata;
  endtask

  task automatic wait_hv(input logic lvl);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (fl_hv_en !== lvl && k < 1000);
  endtask

  task automatic wrap_up();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rng = 32'h15;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = 21'h000000;
    cmd_wdata = 16'h0000;
    wp_level = 1'b1;
    temp_unprotect = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) begin
      slow <= 1'(xs());
      a = 21'(xs() % 32'h1F8000);
      d = 16'(xs());
      op(OP_PROGRAM, a, d); chk(err, 0);
      op(OP_READ, a, 16'h0000); chk(rd, d);
    end
    $display("test random program and read done");
    wp_level <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(protect_accel_pin, 0);
    op(OP_PROGRAM, BOOT_OUTER_BASE, 16'h1234); chk(err, 1);
    op(OP_PROGRAM, BOOT_OUTER_BASE - 21'h000001, 16'h4321); chk(err, 0);
    op(OP_READ, BOOT_OUTER_BASE, 16'h0000); chk(rd, BOOT_OUTER_BASE[15:0] ^ 16'h3C3C);
    wp_level <= 1'b1;
    op(OP_PROGRAM, 21'h1FF000, 16'h5678); chk(err, 0);
    $display("test protect pin done");
    op(OP_SEC_LOCK, 21'h1FF000, 16'h0000); chk(err, 1);
    op(OP_SEC_ENTER, 21'h000000, 16'h0000);
    @(posedge sys_clk);
    chk(secure_mode, 1);
    for (int i = 0; i < 8; i++) begin
      op(OP_READ, 21'h1FF000 + 21'(i), 16'h0000); chk(rd, serial(21'h1FF000 + 21'(i)));
    end
    op(OP_READ, 21'h000100, 16'h0000); chk(err, 1);
    op(OP_ERASE, 21'h1FF000, 16'h0000); chk(err, 1);
    op(OP_SEC_LOCK, 21'h1FF000, 16'h0000); chk(err, 0);
    chk(rd, serial(21'h1FF000 | PROT_ADDR_OFS));
    op(OP_PROGRAM, 21'h1FF000, 16'h0000); chk(err, 0);
    op(OP_READ, 21'h1FF000, 16'h0000); chk(rd, serial(21'h1FF000));
    op(OP_SEC_EXIT, 21'h000000, 16'h0000);
    @(posedge sys_clk);
    chk(secure_mode, 0);
    op(OP_READ, 21'h1FF000, 16'h0000); chk(rd, 16'h5678);
    $display("test secured sector done");
    op(OP_SEC_ENTER, 21'h000000, 16'h0000);
    op(OP_HW_RESET, 21'h000000, 16'h0000);
    @(posedge sys_clk);
    chk(secure_mode, 0);
    op(OP_READ, 21'h1FF000, 16'h0000); chk(rd, 16'h5678);
    $display("test hardware reset done");
    temp_unprotect <= 1'b1;
    wait_hv(1'b1); chk(fl_hv_en, 1);
    op(OP_PROGRAM, 21'h000123, 16'h0F0F); chk(err, 0);
    op(OP_READ, 21'h000123, 16'h0000); chk(rd, 16'h0F0F);
    wp_level <= 1'b0;
    op(OP_PROGRAM, 21'h1FFFFF, 16'hABCD); chk(err, 1);
    op(OP_HW_RESET, 21'h000000, 16'h0000); chk(err, 1);
    temp_unprotect <= 1'b0;
    wait_hv(1'b0); chk(fl_hv_en, 0);
    $display("test high voltage done");
    wrap_up();
  end
endmodule
